// ### hdl/pcdafo_map.vh
// Notes on behaviour
// [RULE_01] Third port: segment on forces pull/dir/inen off
// [RULE_02] Fourth port 7:4 override needs segment and mask
// [RULE_03] Fourth pin one: inen enable OR, value AND
// [RULE_04] Fourth pin one feeds external interrupt zero
// [RULE_05] Fourth pin zero feeds capture input one
// [RULE_06] Clock fuse drives divided clock on pin seven
// [RULE_07] Divided clock stays out during reset; only divided_sysclk_out runs, pin seven resets to input
// [RULE_08] Fifth-port pins are pin-change sources by index
// [RULE_09] Fifth pin six carries serial data output; here usi_do is unused and port_e_out[6] drives pin six
// [RULE_10] Fifth pin five carries serial data input
// [RULE_11] Fifth pin four carries serial clock
// [RULE_12] Fifth pin three feeds comparator negative input
// [RULE_13] Fifth pin two: usart clock or comparator positive
// [RULE_14] Fifth pins one/zero: usart transmit and receive
// [RULE_15] Clock fuse forces pin seven output, drives clock
// [RULE_16] Receiver on forces pin zero input, pull by port
// [RULE_17] Override enable selects override, else register
`ifndef PCDAFO_MAP_VH
`define PCDAFO_MAP_VH
// ----------------------------------------
// Port geometry
// ----------------------------------------
`define PCDAFO_PORT_W 8
`define PCDAFO_PIN_DIVIDED_SYSCLK_OUT 7
`define PCDAFO_PIN_DO 6
`define PCDAFO_PIN_DI 5
`define PCDAFO_PIN_SCK 4
`define PCDAFO_PIN_COMPARATOR_NEG_IN 3
`define PCDAFO_PIN_XCK 2
`define PCDAFO_PIN_TXD 1
`define PCDAFO_PIN_RXD 0
`define PCDAFO_PIN_IRQ 1
`define PCDAFO_PIN_CAP 0
// Reset values
`define PCDAFO_RST_BYTE 8'h00
`define PCDAFO_RST_BIT 1'h0
`endif

// ### hdl/pcdafo_pin.v
`include "pcdafo_map.vh"
// ----------------------------------------
// One pin: override resolution
// ----------------------------------------
module pcdafo_pin (
    input wire pull_override_en,
    input wire pull_override_val,
    input wire dir_override_en,
    input wire dir_override_val,
    input wire outval_override_en,
    input wire outval_override_val,
    input wire inen_override_en,
    input wire inen_override_val,
    input wire reg_pull,
    input wire reg_dir,
    input wire reg_out,
    output wire pull_eff,
    output wire dir_eff,
    output wire out_eff,
    output wire inen_eff
);
    // Override wins when enabled, register otherwise [RULE_17]
    assign pull_eff = pull_override_en ? pull_override_val : reg_pull;
    assign dir_eff = dir_override_en ? dir_override_val : reg_dir;
    assign out_eff = outval_override_en ? outval_override_val : reg_out;
    // Digital input is on by default when not overridden
    assign inen_eff = inen_override_en ? inen_override_val : 1'b1;
endmodule

// ### hdl/pcdafo_top.v
`include "pcdafo_map.vh"
// ----------------------------------------
// Alternate-function override for ports C, D, E
// ----------------------------------------
module pcdafo_top #(
    parameter W = 8
) (
    input wire clk,
    input wire reset_n,
    input wire clk_io,
    input wire segment_driver_on,
    input wire segment_port_mask_sel,
    input wire ext_irq_zero_en,
    input wire clk_out_fuse,
    input wire usi_do,
    input wire receiver_on,
    input wire transmitter_on,
    input wire usart_txd,
    input wire [W-1:0] port_c_out,
    input wire [W-1:0] port_c_dir,
    input wire [W-1:0] port_d_out,
    input wire [W-1:0] port_d_dir,
    input wire [W-1:0] port_e_out,
    input wire [W-1:0] port_e_dir,
    input wire [W-1:0] pull_up_dis,
    input wire [W-1:0] pin_c_in,
    input wire [W-1:0] pin_d_in,
    input wire [W-1:0] pin_e_in,
    output reg [W-1:0] pin_c_out,
    output reg [W-1:0] pin_c_oe_n,
    output reg [W-1:0] pin_c_pull,
    output reg [W-1:0] pin_c_inen,
    output reg [W-1:0] segment_analog_drive_c,
    output reg [W-1:0] pin_d_out,
    output reg [W-1:0] pin_d_oe_n,
    output reg [W-1:0] pin_d_pull,
    output reg [W-1:0] pin_d_inen,
    output reg [W-1:0] segment_analog_drive_d,
    output reg [W-1:0] pin_e_out_reg,
    output reg [W-1:0] pin_e_oe_n,
    output reg [W-1:0] pin_e_pull,
    output reg ext_irq_zero,
    output reg capture_in_one,
    output reg [W-1:0] pin_change_src,
    output reg usi_data_in,
    output reg usi_serial_clk,
    output reg comparator_neg_in,
    output reg comparator_pos_in,
    output reg usart_ext_clk,
    output reg usart_rxd,
    output wire divided_sysclk_out
);
    // ----------------------------------------
    // Override terms
    // ----------------------------------------
    wire seg_masked; // Segment plus mask select
    wire [W-1:0] c_pe, c_de, c_oe, c_ie;
    wire [W-1:0] d_pe, d_de, d_oe, d_ie;
    wire [W-1:0] e_pe, e_de, e_oe, e_ie;
    wire [W-1:0] d_ie_en; // Per-pin input override enable
    wire [W-1:0] d_ie_val; // Per-pin input override value
    wire [W-1:0] e_po_en, e_po_val, e_do_en, e_do_val;
    wire [W-1:0] e_vo_en, e_vo_val;
    wire [W-1:0] e_pull_reg;
    wire e_pull0;
    assign seg_masked = segment_driver_on & segment_port_mask_sel;
    // Pin one: enable on either source, value needs both [RULE_03]
    assign d_ie_en = {{(W-2){seg_masked}},
        segment_driver_on | ext_irq_zero_en, seg_masked};
    assign d_ie_val = {{(W-2){1'b0}},
        segment_driver_on & ext_irq_zero_en, 1'b0};
    // Fifth port: pin seven clock, pin one tx, pin zero rx
    // [RULE_15] [RULE_16]
    assign e_po_en = {{(W-1){1'b0}}, receiver_on};
    assign e_pull0 = port_e_out[`PCDAFO_PIN_RXD] &
        ~pull_up_dis[`PCDAFO_PIN_RXD]; // Pull by port bit [RULE_16]
    assign e_po_val = {{(W-1){1'b0}}, e_pull0};
    assign e_do_en = {clk_out_fuse, {(W-3){1'b0}},
        transmitter_on, receiver_on};
    assign e_do_val = {1'b1, {(W-3){1'b0}}, 1'b1, 1'b0};
    assign e_vo_en = {clk_out_fuse, {(W-3){1'b0}}, transmitter_on, 1'b0};
    assign e_vo_val = {1'b0, {(W-3){1'b0}}, usart_txd, 1'b0};
    assign e_pull_reg = port_e_out & ~port_e_dir & ~pull_up_dis;
    // ----------------------------------------
    // Per-pin resolvers
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_pin
            // Third port: segment forces zeros [RULE_01]
            pcdafo_pin u_c (
                .pull_override_en(segment_driver_on),
                .pull_override_val(1'b0),
                .dir_override_en(segment_driver_on),
                .dir_override_val(1'b0),
                .outval_override_en(1'b0),
                .outval_override_val(1'b0),
                .inen_override_en(segment_driver_on),
                .inen_override_val(1'b0),
                .reg_pull(port_c_out[i] & ~port_c_dir[i] & ~pull_up_dis[i]),
                .reg_dir(port_c_dir[i]),
                .reg_out(port_c_out[i]),
                .pull_eff(c_pe[i]),
                .dir_eff(c_de[i]),
                .out_eff(c_oe[i]),
                .inen_eff(c_ie[i])
            );
            // Fourth port: segment with mask [RULE_02]
            pcdafo_pin u_d (
                .pull_override_en(seg_masked),
                .pull_override_val(1'b0),
                .dir_override_en(seg_masked),
                .dir_override_val(1'b0),
                .outval_override_en(1'b0),
                .outval_override_val(1'b0),
                .inen_override_en(d_ie_en[i]),
                .inen_override_val(d_ie_val[i]),
                .reg_pull(port_d_out[i] & ~port_d_dir[i] & ~pull_up_dis[i]),
                .reg_dir(port_d_dir[i]),
                .reg_out(port_d_out[i]),
                .pull_eff(d_pe[i]),
                .dir_eff(d_de[i]),
                .out_eff(d_oe[i]),
                .inen_eff(d_ie[i])
            );
            pcdafo_pin u_e (
                .pull_override_en(e_po_en[i]),
                .pull_override_val(e_po_val[i]),
                .dir_override_en(e_do_en[i]),
                .dir_override_val(e_do_val[i]),
                .outval_override_en(e_vo_en[i]),
                .outval_override_val(e_vo_val[i]),
                .inen_override_en(1'b0),
                .inen_override_val(1'b0),
                .reg_pull(e_pull_reg[i]),
                .reg_dir(port_e_dir[i]),
                .reg_out(port_e_out[i]),
                .pull_eff(e_pe[i]),
                .dir_eff(e_de[i]),
                .out_eff(e_oe[i]),
                .inen_eff(e_ie[i])
            );
        end
    endgenerate
    // ----------------------------------------
    // Divided clock path
    // ----------------------------------------
    // Gated combinationally so it runs through reset [RULE_06] [RULE_07]
    // Trade-off: a true clock cannot come from a flop of clk
    assign divided_sysclk_out = clk_out_fuse & clk_io;
    // ----------------------------------------
    // Registered pad and peripheral outputs
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // All pads input, no pull during reset
            pin_c_out <= `PCDAFO_RST_BYTE;
            pin_c_oe_n <= ~`PCDAFO_RST_BYTE;
            pin_c_pull <= `PCDAFO_RST_BYTE;
            pin_c_inen <= `PCDAFO_RST_BYTE;
            segment_analog_drive_c <= `PCDAFO_RST_BYTE;
            pin_d_out <= `PCDAFO_RST_BYTE;
            pin_d_oe_n <= ~`PCDAFO_RST_BYTE;
            pin_d_pull <= `PCDAFO_RST_BYTE;
            pin_d_inen <= `PCDAFO_RST_BYTE;
            segment_analog_drive_d <= `PCDAFO_RST_BYTE;
            pin_e_out_reg <= `PCDAFO_RST_BYTE;
            pin_e_oe_n <= ~`PCDAFO_RST_BYTE;
            pin_e_pull <= `PCDAFO_RST_BYTE;
            ext_irq_zero <= `PCDAFO_RST_BIT;
            capture_in_one <= `PCDAFO_RST_BIT;
            pin_change_src <= `PCDAFO_RST_BYTE;
            usi_data_in <= `PCDAFO_RST_BIT;
            usi_serial_clk <= `PCDAFO_RST_BIT;
            comparator_neg_in <= `PCDAFO_RST_BIT;
            comparator_pos_in <= `PCDAFO_RST_BIT;
            usart_ext_clk <= `PCDAFO_RST_BIT;
            usart_rxd <= `PCDAFO_RST_BIT;
        end else begin
            // Third port with analog route [RULE_01]
            pin_c_out <= c_oe;
            pin_c_oe_n <= ~c_de;
            pin_c_pull <= c_pe;
            pin_c_inen <= c_ie;
            segment_analog_drive_c <= {W{segment_driver_on}};
            // Fourth port [RULE_02]
            pin_d_out <= d_oe;
            pin_d_oe_n <= ~d_de;
            pin_d_pull <= d_pe;
            pin_d_inen <= d_ie;
            segment_analog_drive_d <= {W{seg_masked}};
            // Pin seven data is forced to zero when fused, the clock leaves on divided_sysclk_out [RULE_15]
            pin_e_out_reg <= e_oe;
            pin_e_oe_n <= ~e_de;
            pin_e_pull <= e_pe;
            // Taps gated by input enable [RULE_04] [RULE_05]
            ext_irq_zero <= pin_d_in[`PCDAFO_PIN_IRQ] & d_ie[`PCDAFO_PIN_IRQ];
            capture_in_one <= pin_d_in[`PCDAFO_PIN_CAP] &
                d_ie[`PCDAFO_PIN_CAP];
            // Pin-change index equals pin [RULE_08]
            pin_change_src <= pin_e_in & e_ie;
            usi_data_in <= pin_e_in[`PCDAFO_PIN_DI]; // [RULE_10]
            usi_serial_clk <= pin_e_in[`PCDAFO_PIN_SCK]; // [RULE_11]
            comparator_neg_in <= pin_e_in[`PCDAFO_PIN_COMPARATOR_NEG_IN]; // [RULE_12]
            comparator_pos_in <= pin_e_in[`PCDAFO_PIN_XCK]; // [RULE_13]
            usart_ext_clk <= pin_e_in[`PCDAFO_PIN_XCK]; // [RULE_13]
            usart_rxd <= pin_e_in[`PCDAFO_PIN_RXD]; // [RULE_14]
        end
    end
    // Data out on pin six is chosen by the serial unit upstream [RULE_09]
    wire unused_do;
    assign unused_do = usi_do & pin_c_in[0];
endmodule

// ### verification/pcdafo_chk.sv
// ----
// Port override checker
// ----
module pcdafo_chk #(
    parameter W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_io,
    input wire logic segment_driver_on,
    input wire logic segment_port_mask_sel,
    input wire logic ext_irq_zero_en,
    input wire logic clk_out_fuse,
    input wire logic receiver_on,
    input wire logic [W-1:0] port_e_out,
    input wire logic [W-1:0] pull_up_dis,
    input wire logic [W-1:0] pin_d_in,
    input wire logic [W-1:0] pin_e_in,
    input wire logic [W-1:0] pin_c_oe_n,
    input wire logic [W-1:0] pin_c_inen,
    input wire logic [W-1:0] pin_d_oe_n,
    input wire logic [W-1:0] pin_d_inen,
    input wire logic [W-1:0] pin_e_oe_n,
    input wire logic [W-1:0] pin_e_pull,
    input wire logic [W-1:0] pin_change_src,
    input wire logic capture_in_one,
    input wire logic divided_sysclk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rdy_reg; // High once outputs reflect post-reset inputs
    // Arm one edge after release, so $past never sees reset-time inputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rdy_reg <= 1'b0;
        else rdy_reg <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_seg_c; rdy_reg && $past(segment_driver_on) |->
        pin_c_oe_n == {W{1'b1}} && pin_c_inen == {W{1'b0}}; endproperty
    a_seg_c: assert property (p_seg_c) else $error("c override");
    property p_mask_d; rdy_reg && $past(segment_driver_on &&
        segment_port_mask_sel) |-> pin_d_oe_n[7:4] == 4'hF; endproperty
    a_mask_d: assert property (p_mask_d) else $error("d mask");
    property p_irq; rdy_reg |-> pin_d_inen[1] == ($past(segment_driver_on
        | ext_irq_zero_en) ? $past(segment_driver_on & ext_irq_zero_en)
        : 1'b1); endproperty
    a_irq: assert property (p_irq) else $error("irq inen");
    property p_cap; rdy_reg && !$past(segment_driver_on &&
        segment_port_mask_sel) |-> capture_in_one == $past(pin_d_in[0]);
    endproperty
    a_cap: assert property (p_cap) else $error("capture tap");
    // Combinational path, so it is checked through reset as well
    property p_div; @(posedge clk) disable iff (1'b0)
        divided_sysclk_out == (clk_out_fuse & clk_io); endproperty
    a_div: assert property (p_div) else $error("clock out");
    property p_fuse; rdy_reg && $past(clk_out_fuse) |-> !pin_e_oe_n[7];
    endproperty
    a_fuse: assert property (p_fuse) else $error("pin7 dir");
    property p_rx; rdy_reg && $past(receiver_on) |-> pin_e_oe_n[0] &&
        pin_e_pull[0] == $past(port_e_out[0] & ~pull_up_dis[0]); endproperty
    a_rx: assert property (p_rx) else $error("rx input");
    property p_pc; rdy_reg |-> pin_change_src == $past(pin_e_in); endproperty
    a_pc: assert property (p_pc) else $error("pin change");
endmodule
bind pcdafo_top pcdafo_chk #(.W(W)) i_chk (.*);

// ### verification/pcdafo_pad_model.sv
// ----
// Port E pads: driven, pulled, or floating to a moving pattern
// ----
module pcdafo_pad_model (
    input wire logic [7:0] drv,
    input wire logic [7:0] oe_n,
    input wire logic [7:0] pull,
    input wire logic [7:0] ext,
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins never hold the last driven value
    assign pad = (~oe_n & drv) | (oe_n & pull) | (oe_n & ~pull & ext);
endmodule

// ### verification/port_cde_alternate_function_override_tb.sv
// ----
// Random bench with control corners first
// ----
module port_cde_alternate_function_override_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, clk_io, segment_driver_on;
    logic segment_port_mask_sel, ext_irq_zero_en, clk_out_fuse, usi_do;
    logic receiver_on, transmitter_on, usart_txd, ext_irq_zero;
    logic capture_in_one, usi_data_in, usi_serial_clk, comparator_neg_in;
    logic comparator_pos_in, usart_ext_clk, usart_rxd, divided_sysclk_out;
    logic [7:0] port_c_out, port_c_dir, port_d_out, port_d_dir, port_e_out;
    logic [7:0] port_e_dir, pull_up_dis, pin_c_in, pin_d_in, pin_e_in, ext_e;
    logic [7:0] pin_c_out, pin_c_oe_n, pin_c_pull, pin_c_inen, pin_d_out;
    logic [7:0] segment_analog_drive_c, segment_analog_drive_d, pin_d_oe_n;
    logic [7:0] pin_d_pull, pin_d_inen, pin_e_out_reg, pin_e_oe_n;
    logic [7:0] pin_e_pull, pin_change_src, se;
    logic [31:0] seed = 32'h0000974E; // 38734
    int errors = 0, n_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    pcdafo_top #(.W(8)) i_dut (.*);
    pcdafo_pad_model i_pad (.drv({divided_sysclk_out, pin_e_out_reg[6:0]}),
        .oe_n(pin_e_oe_n), .pull(pin_e_pull), .ext(ext_e), .pad(pin_e_in));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic put(input int i); // Corners: first 16 control combos
        logic [31:0] w;
        seed = xs(seed);
        {port_c_out, port_c_dir, port_d_out, port_d_dir} <= seed;
        seed = xs(seed);
        {port_e_out, port_e_dir, pull_up_dis, pin_c_in} <= seed;
        seed = xs(seed);
        w = seed;
        if (i < 16) w[3:0] = i[3:0];
        {pin_d_in, ext_e, usart_txd, transmitter_on, receiver_on, usi_do,
            clk_io, clk_out_fuse, ext_irq_zero_en, segment_port_mask_sel,
            segment_driver_on} <= w[24:0];
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cmp(); // Expectations from inputs held two cycles
        logic m, sg, rx, ir;
        logic [7:0] cp, dp, ep, ex, ob;
        sg = segment_driver_on;
        m = sg & segment_port_mask_sel;
        rx = receiver_on | ~port_e_dir[0];
        ir = (sg | ext_irq_zero_en) ? sg & ext_irq_zero_en : 1'b1;
        cp = port_c_out & ~port_c_dir & ~pull_up_dis;
        dp = port_d_out & ~port_d_dir & ~pull_up_dis;
        ep = port_e_out & ~port_e_dir & ~pull_up_dis;
        check(pin_c_oe_n, sg ? 8'hFF : ~port_c_dir);
        check(pin_c_pull, sg ? 8'h00 : cp);
        check(segment_analog_drive_c | pin_c_inen, 8'hFF);
        check(pin_c_inen, {8{!sg}});
        check(pin_c_out, port_c_out);
        ex = m ? 8'hF0 : {~port_d_dir[7:4], 4'hF};
        check({pin_d_oe_n[7:4], pin_d_inen[7:4]}, ex);
        ex = {m ? 4'hF : ~port_d_dir[3:0], {2{!m}}, ir, !m};
        check({pin_d_oe_n[3:0], pin_d_inen[3:0]}, ex);
        check(pin_d_pull, m ? 8'h00 : dp);
        check(segment_analog_drive_d, {8{m}});
        check(pin_d_out, port_d_out);
        check({7'h00, pin_d_inen[1]}, {7'h00, ir});
        check({7'h00, ext_irq_zero}, {7'h00, pin_d_in[1] & ir});
        ex = {7'h00, pin_d_in[0] & !m};
        check({7'h00, capture_in_one}, ex);
        ex = clk_out_fuse ? 8'h00 : {6'h00, ~port_e_dir[7], port_e_out[7]};
        check({6'h00, pin_e_oe_n[7], pin_e_out_reg[7]}, ex);
        check(pin_change_src, se);
        ob = {usi_data_in, usi_serial_clk, comparator_neg_in,
            comparator_pos_in, usart_ext_clk, 3'h0};
        check(ob, {se[5:2], se[2], 3'h0});
        ex = {6'h00, rx, port_e_out[0] & rx & ~pull_up_dis[0]};
        check({6'h00, pin_e_oe_n[0], pin_e_pull[0]}, ex);
        ob = {6'h00, pin_e_oe_n[1], pin_e_out_reg[1] ^ usart_rxd};
        ex = transmitter_on ? {7'h00, usart_txd ^ se[0]} :
            {6'h00, ~port_e_dir[1], port_e_out[1] ^ se[0]};
        check(ob, ex);
        ob = {pin_e_oe_n[6:2], 3'h0};
        check(ob, {~port_e_dir[6:2], 3'h0});
        ob = {pin_e_out_reg[6:2], 3'h0};
        check(ob, {port_e_out[6:2], 3'h0});
        check({pin_e_pull[7:1], 1'b0}, {ep[7:1], 1'b0});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard: the run needs about 810 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1500) begin
            errors++;
            summarize();
        end
    end
    initial begin
        put(8); // Fuse set while reset is held
        repeat (4) begin
            @(posedge clk);
            clk_io <= ~clk_io;
            @(negedge clk);
            check({7'h00, divided_sysclk_out}, {7'h00, clk_io});
            check(pin_c_oe_n & ~pin_e_out_reg, 8'hFF);
        end
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            put(i);
            @(negedge clk);
            se = pin_e_in; // Pad value the next edge samples
            @(negedge clk);
            cmp();
        end
        summarize();
    end
endmodule
